// [ddr_read_per_bit_deskew_cal_tb_top.sv]
// self-checking bench for the read deskew sequencer
module ddr_read_per_bit_deskew_cal_tb_top;
    import deskew_cal_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gate = 0, mute = 0, err, f1;
    logic [7:0] paddr = 0, stuck = 0, wdat, dq, wr_d;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, dqs, cvld, dqoe, dqsoe, tog, cke, odt, rdb, mpr, rnk;
    cmd_kind_t ckind;
    logic [13:0] addr, mrs_a, wr_a;
    logic [1:0] bg, wr_bg;
    logic [3:0] flags;
    logic [1:0][8:0] rise, fall;
    logic [7:0][8:0] bdl;
    int failures = 0, num_checks = 0, cyc = 0, mrs = 0, wl = 0, mpr_n = 0, dqo_n = 0;
    always #20 clk = ~clk;
    deskew_cal dut_u (.clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .gate_done_in(gate), .dqs_in(dqs),
        .dq_in(dq), .cmd_valid_out(cvld), .cmd_kind_out(ckind), .addr_out(addr),
        .bank_group_out(bg), .rank_out(rnk), .wr_data_out(wdat), .dq_oe_out(dqoe),
        .dqs_oe_out(dqsoe), .dqs_toggle_out(tog), .ck_en_out(cke), .odt_out(odt),
        .rd_burst_out(rdb), .mpr_read_out(mpr), .stage_flags_out(flags),
        .rise_delay_out(rise), .fall_delay_out(fall), .bit_delay_out(bdl));
    dram_model m_u (.clk_in(clk), .rd_burst_in(rdb), .mute_in(mute), .stuck_in(stuck),
        .rise_in(rise), .bit_in(bdl), .dqs_out(dqs), .dq_out(dq));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failures++;
            results();
        end
        if (rst)
        begin
            mrs <= 0;
            wl <= 0;
            mpr_n <= 0;
            dqo_n <= 0;
        end
        if (mpr)
            mpr_n <= mpr_n + 1;
        if (dqoe)
            dqo_n <= dqo_n + 1;
        if (cvld && ckind == CMD_MRS)
        begin
            mrs <= mrs + 1;
            mrs_a <= addr;
        end
        if (cvld && ckind == CMD_WRITE)
        begin
            wr_a <= addr;
            wr_bg <= bg;
            wr_d <= wdat;
        end
        if (cke && odt && tog)
            wl <= wl + 1;
        if (cke && wl == 0)
            f1 <= flags[1];
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        err = pslverr;
        rd = prdata;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic run(input logic [31:0] ctl, input logic m, input logic [7:0] s);
        rst <= 1;
        gate <= 0;
        mute <= m;
        stuck <= s;
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        apb(1, OFF_CTRL, ctl);
        gate <= 1;
        do apb(0, OFF_STATUS, 0); while (rd[5] !== 1'b1 && rd[7] !== 1'b1);
    endtask : run
    task automatic t_regs;
        apb(0, OFF_STATUS, 0);
        cmp(rd, 0);
        apb(0, 8'h20, 0);
        cmp(rd, 0);
        cmp(err, 1);
    endtask : t_regs
    task automatic t_good;
        logic [31:0] eb [4] = '{32'h000C000C, 32'h000C000C, 32'h000F000C, 32'h000F000F};
        run(32'hD, 0, 0);
        cmp(rd[19:0], 20'h0006F);
        cmp({mrs[29:0], mrs_a[8], f1}, {30'd2, 2'b11});
        cmp(mpr_n, CENTER_CYC);
        cmp(dqo_n, 2 * WR_DRIVE_CYC);
        cmp(wl, WL_CYC);
        cmp({wr_a, wr_d}, {ADDR_PAT1_DDR3, DATA_PAT1});
        apb(0, OFF_RISE, 0);
        cmp(rd, 32'h00030000);
        apb(0, OFF_FALL, 0);
        cmp(rd, 32'h00030000);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, OFF_BITDLY + 8'(4 * i), 0);
            cmp(rd, eb[i]);
        end
    endtask : t_good
    task automatic t_err;
        run(32'h3, 1, 0);
        cmp(rd[19:6], {12'h00F, 2'b10});
        cmp({wr_a, wr_bg}, {ADDR_PAT1_DDR4, BG_PAT1_DDR4});
        run(32'h1, 0, 8'h04);
        cmp(rd[19:6], {12'h201, 2'b10});
    endtask : t_err
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs();
        t_good();
        t_err();
        results();
    end
endmodule : ddr_read_per_bit_deskew_cal_tb_top

// [deskew_cal.sv]
// read per-bit deskew sequencer with write leveling front end and apb registers
module deskew_cal
    import deskew_cal_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic gate_done_in,
    input wire logic dqs_in,
    input wire logic [deskew_cal_pkg::BITS-1:0] dq_in,
    output logic cmd_valid_out,
    output deskew_cal_pkg::cmd_kind_t cmd_kind_out,
    output logic [13:0] addr_out,
    output logic [1:0] bank_group_out,
    output logic rank_out,
    output logic [7:0] wr_data_out,
    output logic dq_oe_out,
    output logic dqs_oe_out,
    output logic dqs_toggle_out,
    output logic ck_en_out,
    output logic odt_out,
    output logic rd_burst_out,
    output logic mpr_read_out,
    output logic [3:0] stage_flags_out,
    output logic [deskew_cal_pkg::NIBBLES-1:0][8:0] rise_delay_out,
    output logic [deskew_cal_pkg::NIBBLES-1:0][8:0] fall_delay_out,
    output logic [deskew_cal_pkg::BITS-1:0][8:0] bit_delay_out
);
    import deskew_cal_pkg::*;

    typedef struct packed {
        cal_state_t st;
        logic [11:0] cnt;
        logic rank;
        logic nib;
        logic [1:0] bitn;
        logic [3:0] pass_cnt;
        logic ddr4;
        logic dual;
        logic mirror;
        logic [3:0] flags;
        logic [3:0] err;
        logic [3:0] err_nib;
        logic [3:0] err_bit;
        logic done;
        logic dsk_pass;
        logic dsk_fail;
        logic dqs_d;
        logic [1:0] smp_idx;
        logic burst_par;
        logic ok;
        logic cmd_valid;
        cmd_kind_t cmd_kind;
        logic [13:0] addr;
        logic [1:0] bg;
        logic [7:0] wdata;
        logic drive;
        logic [NIBBLES-1:0][8:0] rise;
        logic [NIBBLES-1:0][8:0] fall;
        logic [BITS-1:0][8:0] idl;
        logic [NIBBLES-1:0][8:0] res_rise;
        logic [NIBBLES-1:0][8:0] res_fall;
        logic [BITS-1:0][8:0] res_idl;
        logic ack;
        logic [31:0] prdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic dqs_s;
    logic [BITS-1:0] dq_s;
    logic [BITS:0] pins_s;

    // strobe and data share one synchroniser so they stay in step
    sync2 #(.WIDTH(BITS + 1)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({dqs_in, dq_in}),
        .sync_out(pins_s)
    );
    assign dqs_s = pins_s[BITS];
    assign dq_s = pins_s[BITS-1:0];

    function automatic logic [8:0] tap_inc(input logic [8:0] v);
        tap_inc = (v == TAP_MAX) ? v : 9'(v + 9'h001);
    endfunction : tap_inc

    function automatic logic [2:0] bit_index(input logic n, input logic [1:0] b);
        bit_index = {n, b};
    endfunction : bit_index

    function automatic logic [31:0] pack_pair(input logic [8:0] lo, input logic [8:0] hi);
        pack_pair = {7'h00, hi, 7'h00, lo};
    endfunction : pack_pair

    logic apb_access;
    logic apb_mapped;
    logic [2:0] cur_bit;
    logic [2:0] widx;
    logic rise_edge;
    logic sample_bit;
    logic decide;
    logic match;
    logic last_bit;
    logic apb_done;

    assign apb_access = psel_in && penable_in;
    // one wait state, so that the registered read data stands when pready is high
    assign apb_done = apb_access && s_r.ack;
    assign apb_mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFF_BITDLY_LAST);
    assign cur_bit = bit_index(s_r.nib, s_r.bitn);
    assign rise_edge = dqs_s && !s_r.dqs_d;
    assign sample_bit = dq_s[cur_bit];
    assign last_bit = (s_r.nib == 1'b1) && (s_r.bitn == 2'h3);
    // only the first rising sample of a burst counts; falling data is never looked at
    assign decide = rise_edge && (s_r.smp_idx == 2'(RISE_USED - 2'h1));
    assign match = s_r.ok && ((sample_bit == s_r.burst_par) || (s_r.smp_idx != 2'h0));

    always_comb
    begin
        s_nxt = s_r;
        widx = 3'h0;
        s_nxt.cmd_valid = 1'b0;
        s_nxt.cmd_kind = CMD_NONE;
        s_nxt.dqs_d = dqs_s;
        s_nxt.prdata = 32'h0000_0000;
        s_nxt.ack = apb_access && !s_r.ack;
        if (apb_access && !s_r.ack && !pwrite_in && apb_mapped)
        begin
            case (paddr_in)
                OFF_CTRL: s_nxt.prdata = {28'h0, s_r.mirror, s_r.dual, s_r.ddr4, 1'b0};
                OFF_STATUS: s_nxt.prdata = {12'h0, s_r.err_bit, s_r.err_nib, s_r.err,
                    s_r.dsk_fail, s_r.dsk_pass, s_r.done, s_r.st != S_IDLE, s_r.flags};
                OFF_RISE: s_nxt.prdata = pack_pair(s_r.res_rise[0], s_r.res_rise[1]);
                OFF_FALL: s_nxt.prdata = pack_pair(s_r.res_fall[0], s_r.res_fall[1]);
                default:
                begin
                    widx = 3'({paddr_in[3:2], 1'b0});
                    s_nxt.prdata = pack_pair(s_r.res_idl[widx], s_r.res_idl[widx + 3'h1]);
                end
            endcase
        end
        // sampling window: count rising strobes within a burst and flip the expected value
        if (s_r.st == S_DSK_EVAL || s_r.st == S_DSK_ALIGN)
        begin
            if (rise_edge)
            begin
                s_nxt.smp_idx = 2'(s_r.smp_idx + 2'h1);
                if (s_r.smp_idx == 2'h0)
                    s_nxt.ok = (sample_bit == s_r.burst_par);
                if (s_r.smp_idx == 2'h3)
                    s_nxt.burst_par = !s_r.burst_par;
            end
        end
        case (s_r.st)
            S_IDLE:
            begin
                if (apb_done && pwrite_in && paddr_in == OFF_CTRL)
                begin
                    s_nxt.ddr4 = pwdata_in[CTRL_DDR4];
                    s_nxt.dual = pwdata_in[CTRL_DUAL];
                    s_nxt.mirror = pwdata_in[CTRL_MIRROR];
                    if (pwdata_in[CTRL_START])
                    begin
                        s_nxt.st = S_GATE_WAIT;
                        s_nxt.flags = 4'h1;
                        s_nxt.done = 1'b0;
                        s_nxt.dsk_pass = 1'b0;
                        s_nxt.dsk_fail = 1'b0;
                        s_nxt.err = ERR_NONE;
                        s_nxt.rank = 1'b0;
                        s_nxt.cnt = 12'h000;
                    end
                end
            end
            S_GATE_WAIT:
            begin
                if (gate_done_in)
                begin
                    s_nxt.st = S_WL_MRS;
                    s_nxt.flags[1] = 1'b1;
                end
            end
            S_WL_MRS:
            begin
                s_nxt.cnt = 12'(s_r.cnt + 12'h001);
                if (s_r.cnt == 12'h000)
                begin
                    s_nxt.cmd_valid = 1'b1;
                    s_nxt.cmd_kind = CMD_MRS;
                    s_nxt.addr = 14'h0000;
                    // a mirrored second rank sees the enable on the swapped address line
                    if (s_r.rank && s_r.mirror)
                        s_nxt.addr[MRS_A7_MIRROR] = 1'b1;
                    else
                        s_nxt.addr[MRS_A7] = 1'b1;
                end
                else if (s_r.cnt == 12'(MRD_CYC))
                begin
                    s_nxt.cnt = 12'h000;
                    if (s_r.dual && !s_r.rank)
                        s_nxt.rank = 1'b1;
                    else
                    begin
                        s_nxt.rank = 1'b0;
                        s_nxt.st = S_WL_RUN;
                    end
                end
            end
            S_WL_RUN:
            begin
                s_nxt.cnt = 12'(s_r.cnt + 12'h001);
                if (s_r.cnt == 12'(WL_CYC - 12'h001))
                begin
                    s_nxt.cnt = 12'h000;
                    s_nxt.st = S_DSK_DEC;
                    s_nxt.flags[2] = 1'b1;
                end
            end
            S_DSK_DEC:
            begin
                s_nxt.st = S_DSK_WR0;
                for (int n = 0; n < NIBBLES; n++)
                begin
                    // the pair stops as soon as either side reaches zero, keeping the offset
                    if (s_r.rise[n] != 9'h000 && s_r.fall[n] != 9'h000)
                    begin
                        s_nxt.rise[n] = 9'(s_r.rise[n] - 9'h001);
                        s_nxt.fall[n] = 9'(s_r.fall[n] - 9'h001);
                        s_nxt.st = S_DSK_DEC;
                    end
                end
            end
            S_DSK_WR0, S_DSK_WR1:
            begin
                s_nxt.cnt = 12'(s_r.cnt + 12'h001);
                s_nxt.drive = 1'b1;
                if (s_r.cnt == 12'h000)
                begin
                    s_nxt.cmd_valid = 1'b1;
                    s_nxt.cmd_kind = CMD_WRITE;
                    s_nxt.rank = 1'b0;
                    if (s_r.st == S_DSK_WR0)
                    begin
                        s_nxt.addr = ADDR_PAT0;
                        s_nxt.bg = 2'h0;
                        s_nxt.wdata = DATA_PAT0;
                    end
                    else
                    begin
                        s_nxt.addr = s_r.ddr4 ? ADDR_PAT1_DDR4 : ADDR_PAT1_DDR3;
                        s_nxt.bg = s_r.ddr4 ? BG_PAT1_DDR4 : 2'h0;
                        s_nxt.wdata = DATA_PAT1;
                    end
                end
                // data and strobe stay driven well past the unknown latency
                else if (s_r.cnt == WR_DRIVE_CYC)
                begin
                    s_nxt.drive = 1'b0;
                    s_nxt.cnt = 12'h000;
                    s_nxt.st = (s_r.st == S_DSK_WR0) ? S_DSK_WR1 : S_DSK_EVAL;
                    s_nxt.nib = 1'b0;
                    s_nxt.bitn = 2'h0;
                    s_nxt.pass_cnt = 4'h0;
                    s_nxt.smp_idx = 2'h0;
                    s_nxt.burst_par = 1'b0;
                end
            end
            S_DSK_EVAL, S_DSK_ALIGN:
            begin
                s_nxt.cnt = rise_edge ? 12'h000 : 12'(s_r.cnt + 12'h001);
                if (s_r.cnt == READ_TIMEOUT_CYC)
                begin
                    s_nxt.st = S_FAIL;
                    s_nxt.err = ERR_TIMEOUT;
                    s_nxt.err_nib = {3'h0, s_r.nib};
                    s_nxt.err_bit = {1'b0, cur_bit};
                end
                else if (decide && s_r.st == S_DSK_EVAL)
                begin
                    if (match)
                    begin
                        s_nxt.idl[cur_bit] = tap_inc(s_r.idl[cur_bit]);
                        s_nxt.pass_cnt = 4'(s_r.pass_cnt + 4'h1);
                        // a single lucky pass in the noisy edge does not close the bit
                        if (4'(s_r.pass_cnt + 4'h1) == WINDOW_MIN)
                        begin
                            s_nxt.pass_cnt = 4'h0;
                            s_nxt.bitn = 2'(s_r.bitn + 2'h1);
                            s_nxt.nib = (s_r.bitn == 2'h3) ? !s_r.nib : s_r.nib;
                            if (last_bit)
                                s_nxt.st = S_DSK_ALIGN;
                        end
                        else if (s_r.idl[cur_bit] == TAP_MAX)
                        begin
                            s_nxt.st = S_FAIL;
                            s_nxt.err = ERR_NO_WINDOW;
                            s_nxt.err_nib = {3'h0, s_r.nib};
                            s_nxt.err_bit = {1'b0, cur_bit};
                        end
                    end
                    else if (s_r.rise[s_r.nib] == TAP_MAX || s_r.fall[s_r.nib] == TAP_MAX)
                    begin
                        s_nxt.st = S_FAIL;
                        s_nxt.err = ERR_NO_WINDOW;
                        s_nxt.err_nib = {3'h0, s_r.nib};
                        s_nxt.err_bit = {1'b0, cur_bit};
                    end
                    else
                    begin
                        // capture delays only ever move later, and always as a pair
                        s_nxt.pass_cnt = 4'h0;
                        s_nxt.rise[s_r.nib] = tap_inc(s_r.rise[s_r.nib]);
                        s_nxt.fall[s_r.nib] = tap_inc(s_r.fall[s_r.nib]);
                    end
                end
                else if (decide)
                begin
                    if (match && s_r.idl[cur_bit] != TAP_MAX)
                        s_nxt.idl[cur_bit] = tap_inc(s_r.idl[cur_bit]);
                    else
                    begin
                        s_nxt.bitn = 2'(s_r.bitn + 2'h1);
                        s_nxt.nib = (s_r.bitn == 2'h3) ? !s_r.nib : s_r.nib;
                        if (last_bit)
                        begin
                            s_nxt.st = S_CENTER;
                            s_nxt.cnt = 12'h000;
                            s_nxt.res_rise = s_r.rise;
                            s_nxt.res_fall = s_r.fall;
                            s_nxt.res_idl = s_r.idl;
                            s_nxt.dsk_pass = 1'b1;
                            s_nxt.flags[3] = 1'b1;
                        end
                    end
                end
            end
            S_CENTER:
            begin
                s_nxt.cnt = 12'(s_r.cnt + 12'h001);
                if (s_r.cnt == 12'(CENTER_CYC - 12'h001))
                    s_nxt.st = S_DONE;
            end
            S_DONE:
            begin
                s_nxt.done = 1'b1;
                s_nxt.st = S_IDLE;
            end
            S_FAIL:
            begin
                s_nxt.dsk_fail = 1'b1;
                s_nxt.st = S_IDLE;
            end
            default: s_nxt.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            s_r.cmd_kind <= CMD_NONE;
            for (int n = 0; n < NIBBLES; n++)
            begin
                s_r.rise[n] <= TAP_RESET;
                s_r.fall[n] <= TAP_RESET;
            end
        end
        else
            s_r <= s_nxt;
    end

    assign pready_out = apb_done;
    assign pslverr_out = apb_done && !apb_mapped;
    assign prdata_out = s_r.prdata;
    assign cmd_valid_out = s_r.cmd_valid;
    assign cmd_kind_out = s_r.cmd_kind;
    assign addr_out = s_r.addr;
    assign bank_group_out = s_r.bg;
    assign rank_out = s_r.rank;
    assign wr_data_out = s_r.wdata;
    assign dq_oe_out = s_r.drive;
    assign dqs_oe_out = s_r.drive || (s_r.st == S_WL_RUN);
    assign dqs_toggle_out = (s_r.st == S_WL_RUN) || s_r.drive;
    assign ck_en_out = (s_r.st == S_WL_RUN);
    assign odt_out = (s_r.st == S_WL_RUN);
    assign rd_burst_out = (s_r.st == S_DSK_EVAL) || (s_r.st == S_DSK_ALIGN);
    assign mpr_read_out = (s_r.st == S_CENTER);
    assign stage_flags_out = s_r.flags;
    assign rise_delay_out = s_r.rise;
    assign fall_delay_out = s_r.fall;
    assign bit_delay_out = s_r.idl;

    chk_wl_flag_rise: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_r.st == S_GATE_WAIT && gate_done_in) |=> stage_flags_out[1])
        else $error("write leveling flag not raised");
    chk_wl_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
        ck_en_out |-> (odt_out && dqs_toggle_out))
        else $error("termination or strobe missing during leveling");
    chk_mrs_a7: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_valid_out && cmd_kind_out == CMD_MRS && !(rank_out && s_r.mirror)) |-> addr_out[7])
        else $error("mode register set lacks A7");
    chk_dec_lock: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_r.st == S_DSK_DEC) |=> (($past(s_r.rise[0]) - s_r.rise[0])
            == ($past(s_r.fall[0]) - s_r.fall[0])))
        else $error("rise and fall delays not stepped together");
    chk_cap_mono: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_r.st == S_DSK_EVAL && $past(s_r.st) == S_DSK_EVAL) |-> (s_r.rise[0] >= $past(s_r.rise[0])))
        else $error("capture delay decreased during deskew");
    chk_wr_drive: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_valid_out && cmd_kind_out == CMD_WRITE) |-> dq_oe_out [*8])
        else $error("write data not held long enough");
    chk_pat1_ddr4: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_valid_out && cmd_kind_out == CMD_WRITE && wr_data_out == DATA_PAT1 && s_r.ddr4)
        |-> (bank_group_out == BG_PAT1_DDR4))
        else $error("second pattern not in other bank group");
    chk_timeout_err: assert property (@(posedge clk_in) disable iff (rst_in)
        (rd_burst_out && s_r.cnt == READ_TIMEOUT_CYC) |=> (s_r.err == ERR_TIMEOUT) ##1 s_r.dsk_fail)
        else $error("read timeout not reported");
    chk_result_store: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(s_r.dsk_pass) |-> (s_r.res_rise == s_r.rise && s_r.res_idl == s_r.idl))
        else $error("results not stored on completion");
    chk_reads_cont: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(rd_burst_out) |-> rd_burst_out [*4])
        else $error("read bursts have gaps");
endmodule : deskew_cal

// [deskew_cal_pkg.sv]
// constants, register map and state encoding for the read deskew sequencer
// Operation
// - raise stage flag bit 1 at write leveling
// - toggle strobe and clock during write leveling
// - mode register set with A7, mirrored per rank
// - termination on while strobe toggles in write leveling, off for pattern writes
// - read leveling after gate and write leveling
// - center strobe with register pattern after deskew
// - deskew first rank only, written long pattern
// - per nibble rise and fall 512-tap delays
// - keep rise and fall delays offset together
// - write 0x00 at 0x000, eight extra cycles
// - back-to-back reads without gaps during evaluation
// - decrement rise and fall together until zero
// - compare rising data only, drop burst tail
// - match bumps bit delay, mismatch bumps capture
// - window needs ten contiguous passing settings
// - one bit at a time, capture never decreases
// - recheck all bits, push early bits
// - store final delays as readable results
// - no window gives error 0x1 with location
// - read timeout gives error 0xF with location
package deskew_cal_pkg;
    localparam int NIBBLES = 2;
    localparam int BITS = 8;
    localparam int TAP_W = 9;
    localparam logic [8:0] TAP_MAX = 9'h1FF;
    localparam logic [8:0] TAP_RESET = 9'h000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int WL_TIME_NS = 4000;
    localparam logic [11:0] WL_CYC = 12'((WL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int READ_TIMEOUT_NS = 2000;
    localparam logic [11:0] READ_TIMEOUT_CYC = 12'(READ_TIMEOUT_NS / CLK_PERIOD_NS);
    localparam int MRD_CYC = 8;
    localparam int WR_LAT_CYC = 9;
    localparam int WR_EXTRA_CYC = 8;
    localparam int BURST_CLK = 4;
    localparam logic [11:0] WR_DRIVE_CYC = 12'(WR_EXTRA_CYC + WR_LAT_CYC + BURST_CLK + WR_EXTRA_CYC);
    localparam logic [11:0] CENTER_CYC = 12'h040;
    localparam logic [3:0] WINDOW_MIN = 4'hA;
    localparam logic [1:0] RISE_USED = 2'h2;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_NO_WINDOW = 4'h1;
    localparam logic [3:0] ERR_TIMEOUT = 4'hF;
    localparam int MRS_A7 = 7;
    localparam int MRS_A7_MIRROR = 8;
    localparam logic [13:0] ADDR_PAT0 = 14'h0000;
    localparam logic [13:0] ADDR_PAT1_DDR3 = 14'h0008;
    localparam logic [13:0] ADDR_PAT1_DDR4 = 14'h0000;
    localparam logic [1:0] BG_PAT1_DDR4 = 2'h1;
    localparam logic [7:0] DATA_PAT0 = 8'h00;
    localparam logic [7:0] DATA_PAT1 = 8'hFF;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RISE = 8'h08;
    localparam logic [7:0] OFF_FALL = 8'h0C;
    localparam logic [7:0] OFF_BITDLY = 8'h10;
    localparam logic [7:0] OFF_BITDLY_LAST = 8'h1C;
    localparam int CTRL_START = 0;
    localparam int CTRL_DDR4 = 1;
    localparam int CTRL_DUAL = 2;
    localparam int CTRL_MIRROR = 3;
    typedef enum logic [1:0] {CMD_NONE, CMD_MRS, CMD_WRITE, CMD_READ} cmd_kind_t;
    typedef enum {
        S_IDLE, S_GATE_WAIT, S_WL_MRS, S_WL_RUN, S_DSK_DEC, S_DSK_WR0, S_DSK_WR1,
        S_DSK_EVAL, S_DSK_ALIGN, S_CENTER, S_DONE, S_FAIL
    } cal_state_t;
endpackage : deskew_cal_pkg

// [dram_model.sv]
// memory side model: read strobes and burst data with per-bit skew
module dram_model
    import deskew_cal_pkg::*;
(
    input wire logic clk_in,
    input wire logic rd_burst_in,
    input wire logic mute_in,
    input wire logic [7:0] stuck_in,
    input wire logic [deskew_cal_pkg::NIBBLES-1:0][8:0] rise_in,
    input wire logic [deskew_cal_pkg::BITS-1:0][8:0] bit_in,
    output logic dqs_out,
    output logic [7:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] e = 8'h00;
    int r;
    int g;
    initial
    begin
        dqs_out = 1'b0;
        dq_out = 8'h00;
    end
    // bit 4 lags by three taps so its nibble strobe must be pushed out
    always
    begin
        if (rd_burst_in && !mute_in)
        begin
            // bursts alternate 00 and FF, no gap between them
            for (int b = 0; b < 8; b++)
            begin
                r = rise_in[b/4];
                g = (b == 4) ? 3 : 0;
                dq_out[b] = e[2] ^ stuck_in[b] ^ !(r >= g && bit_in[b] <= r - g + 11);
            end
            #160 dqs_out = 1'b1;
            #160 dqs_out = 1'b0;
            e = e + 8'h01;
        end
        else
        begin
            // strobe stands still between frames, data lines wander
            e = 8'h00;
            dqs_out = 1'b0;
            dq_out = ~dq_out;
            @(posedge clk_in);
        end
    end
endmodule : dram_model

// [sync2.sv]
// two flip-flop synchroniser for pins from the memory side
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : sync2
